/* File: shared/erai_pkg.sv */
// Purpose: Constants and types for the E1 receive alarm interrupt block
// Assumes: One clock (ref_clk, 40 MHz), synchronous active-high reset
// Notes:   Register map sits behind an AXI4-Lite slave
package erai_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DEC_W = 4;
  localparam logic [3:0] OFS_EXCESS_ZERO_CHANGE_FLAG = 4'h0;
  localparam logic [3:0] OFS_EXZ_ENABLE = 4'h4;
  localparam logic [3:0] OFS_ALM_STATUS = 4'h8;
  localparam logic [3:0] OFS_ALM_ENABLE = 4'hc;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EXZ_SA7_STATE_BIT = 5;
  localparam int ALM_TS16_STATE_BIT = 4;
  localparam int EXZ_FLAG_W = 2;
  localparam int ALM_FLAG_W = 4;
  localparam logic [7:0] EXZ_ENABLE_RST = 8'h00;
  localparam logic [7:0] ALM_ENABLE_RST = 8'h00;

  // Flag order: exz, sa7, ts16, cas, crc, los
  localparam int NUM_FLAGS = 6;
  localparam int FLG_EXZ = 0;
  localparam int FLG_SA7 = 1;
  localparam int FLG_TS16 = 2;
  localparam int FLG_CAS = 3;
  localparam int FLG_CRC = 4;
  localparam int FLG_LOS = 5;

  // ----------------------------------------------------------------
  // Bus answers and vote window
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] VOTE_WIN_RST = 3'h7;

  typedef struct packed {
    logic sa7_bit;
    logic sa7_strobe;
    logic excess_zero;
    logic rx_signal_loss;
    logic crc_lock;
    logic cas_lock;
    logic ts16_all_ones;
  } erai_alarm_in_t;

endpackage

/* File: verilog/erai_sa7_vote.sv */
// Purpose: Two-of-three zero vote on received Sa7 samples
// Assumes: sample_strobe marks one new Sa7 bit
// Notes:   Window starts all ones so reset never declares zero
module erai_sa7_vote (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sample_bit,
  input wire logic sample_strobe,
  output logic zero_state
);
  import erai_pkg::*;

  logic [2:0] win_reg;
  logic [2:0] win_next;
  logic [2:0] zeros;
  logic vote;

  assign win_next = {win_reg[1:0], sample_bit};
  assign zeros = ~win_next;
  assign vote = (zeros[0] & zeros[1]) | (zeros[0] & zeros[2]) |
                (zeros[1] & zeros[2]);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      win_reg <= VOTE_WIN_RST;
      zero_state <= 1'b0;
    end else if (sample_strobe) begin
      win_reg <= win_next;
      zero_state <= vote;
    end
  end
endmodule // erai_sa7_vote

/* File: verilog/erai_change_flag.sv */
// Purpose: Sticky flag set by any change of a level
// Assumes: Level is synchronous to ref_clk
// Notes:   A change in the clear cycle keeps the flag set
module erai_change_flag (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic level,
  input wire logic clear,
  output logic flag
);
  logic prev_reg;
  logic changed;

  assign changed = level ^ prev_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_reg <= 1'b0;
      flag <= 1'b0;
    end else begin
      prev_reg <= level;
      // Set beats clear so no edge is lost
      flag <= changed | (flag & ~clear);
    end
  end
endmodule // erai_change_flag

/* File: verilog/erai_top.sv */
// Purpose: Interrupt status and enables for E1 receive alarms
// Assumes: Alarm levels come from the framer, synchronous to ref_clk
// Notes:   AXI4-Lite slave, one read and one write in flight
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
module erai_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire erai_pkg::erai_alarm_in_t alarm_in,
  input wire logic [erai_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [erai_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import erai_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_full_reg;
  logic aw_full_next;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic w_full_next;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic bvalid_next;
  logic [1:0] bresp_next;
  logic rvalid_next;
  logic [7:0] exz_en_reg;
  logic [7:0] alm_en_reg;
  logic irq_next;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic b_fire;
  logic r_fire;
  logic aw_ok;
  logic w_ok;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic wr_upper_zero;
  logic wr_hit_exz_st;
  logic wr_hit_exz_en;
  logic wr_hit_alm_st;
  logic wr_hit_alm_en;
  logic wr_mapped;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_upper_zero;
  logic rd_hit_exz_st;
  logic rd_hit_exz_en;
  logic rd_hit_alm_st;
  logic rd_hit_alm_en;
  logic rd_mapped;
  logic [7:0] rd_byte;

  logic sa7_zero_state;
  logic [NUM_FLAGS-1:0] level_vec;
  logic [NUM_FLAGS-1:0] flag_vec;
  logic [NUM_FLAGS-1:0] clear_vec;
  logic [NUM_FLAGS-1:0] en_eff;
  logic [EXZ_FLAG_W-1:0] exz_clear;
  logic [ALM_FLAG_W-1:0] alm_clear;
  logic [7:0] excess_zero_change_flag;
  logic [7:0] alm_status;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign b_fire = s_axi_bvalid & s_axi_bready;
  assign r_fire = s_axi_rvalid & s_axi_rready;

  // Address and data may arrive in either order
  assign aw_ok = aw_full_reg | aw_fire;
  assign w_ok = w_full_reg | w_fire;
  assign wr_go = aw_ok & w_ok;

  assign aw_full_next = aw_ok & ~wr_go;
  assign w_full_next = w_ok & ~wr_go;
  assign bvalid_next = wr_go | (s_axi_bvalid & ~b_fire);
  assign bresp_next = wr_go ? (wr_mapped ? RESP_OKAY : RESP_SLVERR)
                            : s_axi_bresp;
  assign rvalid_next = ar_fire | (s_axi_rvalid & ~r_fire);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_full_reg ? w_data_reg : s_axi_wdata[7:0];
  assign wr_lane0 = w_full_reg ? w_strb_reg : s_axi_wstrb[0];
  // Upper address bits must be zero; no aliasing
  assign wr_upper_zero = (wr_addr[ADDR_W-1:DEC_W] == '0);
  assign wr_hit_exz_st = wr_upper_zero &
                         (wr_addr[DEC_W-1:2] == OFS_EXCESS_ZERO_CHANGE_FLAG[3:2]);
  assign wr_hit_exz_en = wr_upper_zero &
                         (wr_addr[DEC_W-1:2] == OFS_EXZ_ENABLE[3:2]);
  assign wr_hit_alm_st = wr_upper_zero &
                         (wr_addr[DEC_W-1:2] == OFS_ALM_STATUS[3:2]);
  assign wr_hit_alm_en = wr_upper_zero &
                         (wr_addr[DEC_W-1:2] == OFS_ALM_ENABLE[3:2]);
  assign wr_mapped = wr_hit_exz_st | wr_hit_exz_en |
                     wr_hit_alm_st | wr_hit_alm_en;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  assign rd_addr = s_axi_araddr;
  assign rd_upper_zero = (rd_addr[ADDR_W-1:DEC_W] == '0);
  assign rd_hit_exz_st = rd_upper_zero &
                         (rd_addr[DEC_W-1:2] == OFS_EXCESS_ZERO_CHANGE_FLAG[3:2]);
  assign rd_hit_exz_en = rd_upper_zero &
                         (rd_addr[DEC_W-1:2] == OFS_EXZ_ENABLE[3:2]);
  assign rd_hit_alm_st = rd_upper_zero &
                         (rd_addr[DEC_W-1:2] == OFS_ALM_STATUS[3:2]);
  assign rd_hit_alm_en = rd_upper_zero &
                         (rd_addr[DEC_W-1:2] == OFS_ALM_ENABLE[3:2]);
  assign rd_mapped = rd_hit_exz_st | rd_hit_exz_en |
                     rd_hit_alm_st | rd_hit_alm_en;

  // ----------------------------------------------------------------
  // Status views
  // ----------------------------------------------------------------
  // Bits 4..2 of the excess-zero status read as zero
  assign excess_zero_change_flag = {2'h0,
                       sa7_zero_state,
                       3'h0,
                       flag_vec[FLG_SA7],
                       flag_vec[FLG_EXZ]};
  assign alm_status = {3'h0,
                       alarm_in.ts16_all_ones,
                       flag_vec[FLG_LOS],
                       flag_vec[FLG_CRC],
                       flag_vec[FLG_CAS],
                       flag_vec[FLG_TS16]};

  assign rd_byte = rd_hit_exz_st ? excess_zero_change_flag :
                   rd_hit_exz_en ? exz_en_reg :
                   rd_hit_alm_st ? alm_status :
                   rd_hit_alm_en ? alm_en_reg : 8'h00;

  // ----------------------------------------------------------------
  // Flag clearing
  // ----------------------------------------------------------------
  // Reading a status register clears every change bit in it;
  // writing ones clears the chosen bits.
  assign exz_clear =
    (ar_fire & rd_hit_exz_st) ? {EXZ_FLAG_W{1'b1}} :
    (wr_go & wr_lane0 & wr_hit_exz_st) ?
      wr_data[EXZ_FLAG_W-1:0] : '0;
  assign alm_clear =
    (ar_fire & rd_hit_alm_st) ? {ALM_FLAG_W{1'b1}} :
    (wr_go & wr_lane0 & wr_hit_alm_st) ?
      wr_data[ALM_FLAG_W-1:0] : '0;
  assign clear_vec = {alm_clear, exz_clear};

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  erai_sa7_vote u_sa7_vote (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sample_bit(alarm_in.sa7_bit),
    .sample_strobe(alarm_in.sa7_strobe),
    .zero_state(sa7_zero_state)
  );

  assign level_vec[FLG_EXZ] = alarm_in.excess_zero;
  assign level_vec[FLG_SA7] = sa7_zero_state;
  assign level_vec[FLG_TS16] = alarm_in.ts16_all_ones;
  assign level_vec[FLG_CAS] = alarm_in.cas_lock;
  assign level_vec[FLG_CRC] = alarm_in.crc_lock;
  assign level_vec[FLG_LOS] = alarm_in.rx_signal_loss;

  // Flags latch whatever the enables say; enables gate irq only
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    erai_change_flag u_flag (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .level(level_vec[i]),
      .clear(clear_vec[i]),
      .flag(flag_vec[i])
    );
  end

  // ----------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------
  assign en_eff[FLG_EXZ] = exz_en_reg[FLG_EXZ];
  assign en_eff[FLG_SA7] = exz_en_reg[FLG_SA7];
  // Alarm enables as printed: a zero turns the source on
  assign en_eff[FLG_TS16] = ~alm_en_reg[0];
  assign en_eff[FLG_CAS] = ~alm_en_reg[1];
  assign en_eff[FLG_CRC] = ~alm_en_reg[2];
  assign en_eff[FLG_LOS] = ~alm_en_reg[3];

  assign irq_next = |(flag_vec & en_eff);

  // ----------------------------------------------------------------
  // Write channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_fire) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
    end
  end

  // Ready drops while a word is held or a response waits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
    end
  end

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  // Only the low byte lane holds data; upper bits read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      exz_en_reg <= EXZ_ENABLE_RST;
      alm_en_reg <= ALM_ENABLE_RST;
    end else if (wr_go & wr_lane0) begin
      if (wr_hit_exz_en) begin
        exz_en_reg <= {6'h00, wr_data[1:0]};
      end
      if (wr_hit_alm_en) begin
        alm_en_reg <= {4'h0, wr_data[3:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_fire) begin
        // Snapshot taken in the same edge that clears the flags
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

endmodule // erai_top

/* File: tb/erai_monitor.sv */
// Purpose: Port-level relations of the alarm interrupt block
// Assumes: One clock, synchronous active-high reset
// Notes: Bus answers are one cycle after the take edge
module erai_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire erai_pkg::erai_alarm_in_t alarm_in,
  input wire logic [erai_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [erai_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import erai_pkg::*;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire aw_go = s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready;
  wire ar_go = s_axi_arvalid && s_axi_arready;
  b_answer_a: assert property (aw_go |=> s_axi_bvalid)
    else $error("write answer missing");
  aw_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  b_unmapped_a: assert property (aw_go && s_axi_awaddr[31:4] != 28'h0
    |=> s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
  r_answer_a: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer missing");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  r_unmapped_a: assert property (ar_go && s_axi_araddr[31:4] != 28'h0
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  r_reserved_a: assert property (ar_go && s_axi_araddr[31:4] == 28'h0
    |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read bad answer");
  ts16_live_a: assert property (ar_go && s_axi_araddr == 32'h8
    |=> s_axi_rdata[4] == $past(alarm_in.ts16_all_ones))
    else $error("live all-ones bit wrong");
  rst_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule // erai_monitor

bind erai_top erai_monitor mon_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .alarm_in(alarm_in), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .irq(irq));

/* File: tb/tb_e1_rx_alarm_interrupts.sv */
// Purpose: Self-checking bench for the alarm interrupt block
// Assumes: AXI4-Lite master driven on rising edges
// Notes: Protection inputs are tied; strobe is driven
module tb_e1_rx_alarm_interrupts;
  timeunit 1ns;
  timeprecision 100ps;
  import erai_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  erai_alarm_in_t alarm_in = '0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [31:0] s_axi_rdata, d, e, live;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_fail = 0, n_checks = 0, cyc = 0, k;

  erai_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .alarm_in(alarm_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

  // ------------------------------------------------------------
  // Clock, timeout, reporting
  // ------------------------------------------------------------
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t irq %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr_chk(input logic [31:0] a, input logic [31:0] v);
    wr(a, v);
    chk_val({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    chk_val(d, exp);
    chk_val({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic sa7(input logic b);
    alarm_in.sa7_bit <= b;
    alarm_in.sa7_strobe <= 1'b1;
    @(posedge ref_clk);
    alarm_in.sa7_strobe <= 1'b0;
    tick(3);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (k = 0; k < 4; k++) begin
      rd_chk(32'(k * 4), 32'h0);
    end
    chk_bit(irq, 1'b0);
  endtask
  task automatic t_alarm();
    for (k = 0; k < 4; k++) begin
      e = 32'h1 << k;
      live = (k == 0) ? 32'h10 : 32'h0;
      alarm_in[k] <= 1'b1;
      tick(4);
      chk_bit(irq, 1'b1);
      rd_chk(32'h8, live | e);
      tick(3);
      chk_bit(irq, 1'b0);
      rd_chk(32'h8, live);
      alarm_in[k] <= 1'b0;
      tick(4);
      rd_chk(32'h8, e);
    end
    wr_chk(32'hc, 32'hf);
    alarm_in[3:0] <= 4'hf;
    tick(4);
    chk_bit(irq, 1'b0);
    wr_chk(32'hc, 32'h0);
    tick(2);
    chk_bit(irq, 1'b1);
    wr_chk(32'h8, 32'hf);
    tick(3);
    chk_bit(irq, 1'b0);
    rd_chk(32'h8, 32'h10);
    alarm_in[3:0] <= 4'h0;
    tick(4);
    rd_chk(32'h8, 32'hf);
  endtask
  task automatic t_exz();
    alarm_in.excess_zero <= 1'b1;
    tick(4);
    chk_bit(irq, 1'b0);
    rd_chk(32'h0, 32'h1);
    wr_chk(32'h4, 32'h1);
    alarm_in.excess_zero <= 1'b0;
    tick(4);
    chk_bit(irq, 1'b1);
    rd_chk(32'h0, 32'h1);
    tick(3);
    chk_bit(irq, 1'b0);
  endtask
  task automatic t_sa7();
    wr_chk(32'h4, 32'h2);
    sa7(1'b0);
    rd_chk(32'h0, 32'h0);
    sa7(1'b0);
    chk_bit(irq, 1'b1);
    rd_chk(32'h0, 32'h22);
    sa7(1'b1);
    rd_chk(32'h0, 32'h20);
    sa7(1'b1);
    chk_bit(irq, 1'b1);
    rd_chk(32'h0, 32'h2);
  endtask
  task automatic t_map();
    rd(32'h10);
    chk_val(d, 32'h0);
    chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(32'h10, 32'hff);
    chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
    wr_chk(32'h4, 32'hff);
    rd_chk(32'h4, 32'h3);
    // Lane 0 off: write answered but dropped
    s_axi_wstrb <= 4'h0;
    wr_chk(32'h4, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd_chk(32'h4, 32'h3);
    wr_chk(32'hc, 32'hff);
    rd_chk(32'hc, 32'hf);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(2);
    t_reset();
    t_alarm();
    t_exz();
    t_sa7();
    t_map();
    conclude();
  end
endmodule // tb_e1_rx_alarm_interrupts
